// *** pkg/ecpu_pkg.sv ***
// constants and types shared by the 8-bit core datapath
// assumes a single 250 MHz clock; all steps advance on a phase-one enable
//
// Functional notes
// - step counter returns to zero on every opcode fetch
// - step counter advances once per phase-one pulse until instruction completes
// - sixteen-bit program counter supplies sequential program addresses
// - fetch address is pc high byte over pc low byte
// - pc increments on every instruction or operand byte fetched
// - opcode latched from data bus, decoded with step count and interrupts
// - all arithmetic and register inc/dec go through the arith_logic_unit, pc excepted
// - eight-bit accumulator supplies one operand and receives most results
// - two eight-bit index registers for counting and effective addresses
// - indexed modes add the index to the base before the access
// - eight-bit stack pointer addresses a stack in page one
// - stack pointer moves automatically for instruction and interrupt stack traffic
// - seven status flags held in an eight-bit status register
// - some flags change only by instructions, others also by the core
// - address output narrowed to 12, 13 or 16 lines
// - zero-page indexed addresses never carry into the high byte
package ecpu_pkg;

    // ========================================
    // timing
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          PHASE_DIV     = 2;  // clock cycles per phase-one step

    // ========================================
    // address layout
    localparam logic [7:0]  STACK_PAGE    = 8'h01;
    localparam logic [7:0]  ZERO_PAGE     = 8'h00;
    localparam logic [15:0] NMI_VECTOR    = 16'hfffa;
    localparam logic [15:0] IRQ_VECTOR    = 16'hfffe;

    // ========================================
    // reset values
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [7:0]  SP_RESET      = 8'h00;
    localparam logic [7:0]  STATUS_RESET  = 8'h24;

    // ========================================
    // status flag positions; bit 5 is not a flag and reads one
    localparam int          FLAG_C        = 0;
    localparam int          FLAG_Z        = 1;
    localparam int          FLAG_I        = 2;
    localparam int          FLAG_D        = 3;
    localparam int          FLAG_B        = 4;
    localparam int          FLAG_ONE      = 5;
    localparam int          FLAG_V        = 6;
    localparam int          FLAG_N        = 7;

    // ========================================
    // opcode layout: [7:6] class, [5:3] operation, [1:0] address mode
    localparam logic [1:0]  CLS_ALU       = 2'h0;
    localparam logic [1:0]  CLS_STORE     = 2'h1;
    localparam logic [1:0]  CLS_IMPLIED   = 2'h2;
    localparam logic [1:0]  CLS_JUMP      = 2'h3;
    localparam logic [1:0]  MODE_IMM      = 2'h0;
    localparam logic [1:0]  MODE_ZP       = 2'h1;
    localparam logic [1:0]  MODE_ZP_X     = 2'h2;
    localparam logic [1:0]  MODE_ABS_Y    = 2'h3;
    localparam logic [2:0]  STEP_IMM      = 3'h1;
    localparam logic [2:0]  STEP_ZP       = 3'h2;
    localparam logic [2:0]  STEP_ZP_X     = 3'h3;
    localparam logic [2:0]  STEP_ABS_Y    = 3'h5;

    // arith_logic_unit operations
    typedef enum logic [2:0] {
        ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_INC, ALU_DEC
    } ecpu_alu_e;

endpackage

// *** rtl/ecpu_core.sv ***
// 8-bit core datapath: step counter, program counter, decoder, arith_logic_unit,
// accumulator, two index registers, page-one stack pointer and status register
// assumes memory answers data_in_in for addr_out within the same phase-one step
`timescale 1ns/100ps
`default_nettype none
module ecpu_core
    import ecpu_pkg::*;
#(
    parameter int ADDR_LINES = 16
)
(
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [7:0]  data_in_in,
    input  wire logic        irq_in,
    input  wire logic        nmi_in,
    output logic      [15:0] addr_out,
    output logic      [7:0]  data_out,
    output logic             write_out,
    output logic             sync_out,
    output logic             phase_one_out
);

    // ========================================
    // state
    logic [7:0]  div_cnt;
    logic [2:0]  step;
    logic [15:0] pc;
    logic [7:0]  ir;
    logic [7:0]  acc;
    logic [7:0]  x_reg;
    logic [7:0]  y_reg;
    logic [7:0]  sp;
    logic [7:0]  status;
    logic [7:0]  base_lo;
    logic [7:0]  base_hi;
    logic        carry_tmp;
    logic        int_active;
    logic        int_nmi;
    logic        nmi_prev;
    logic        nmi_pend;
    logic        irq_hold;

    logic [2:0]  next_step;
    logic [15:0] next_pc;
    logic [7:0]  next_ir;
    logic [7:0]  next_acc;
    logic [7:0]  next_x_reg;
    logic [7:0]  next_y_reg;
    logic [7:0]  next_sp;
    logic [7:0]  next_status;
    logic [7:0]  next_base_lo;
    logic [7:0]  next_base_hi;
    logic        next_carry_tmp;
    logic        next_int_active;
    logic        next_int_nmi;
    logic        int_taken;
    logic        done;
    logic [15:0] addr_mux;
    logic [7:0]  dout_mux;
    logic        wr_mux;
    logic        fetch_mux;
    logic [9:0]  alu_r;

    // ========================================
    // decode wires
    wire         step_en   = (div_cnt == 8'(PHASE_DIV - 1));
    wire  [1:0]  op_cls    = ir[7:6];
    wire  [2:0]  op_sel    = ir[5:3];
    wire  [3:0]  op_imp    = ir[3:0];
    wire  [1:0]  op_mode   = (op_cls == CLS_STORE && ir[1:0] == MODE_IMM) ? MODE_ZP : ir[1:0];
    wire  [2:0]  exec_step = (op_mode == MODE_IMM) ? STEP_IMM :
                             (op_mode == MODE_ZP)  ? STEP_ZP  :
                             (op_mode == MODE_ZP_X) ? STEP_ZP_X : STEP_ABS_Y;
    wire  [15:0] pc_plus   = pc + 16'h0001;           // separate incrementer
    wire  [15:0] stack_adr = {STACK_PAGE, sp};
    wire  [15:0] vec_adr   = int_nmi ? NMI_VECTOR : IRQ_VECTOR;
    wire  [15:0] eff_adr   = {base_hi, base_lo};
    wire         nmi_edge  = nmi_in && !nmi_prev;
    wire         int_req   = nmi_pend || (irq_hold && !status[FLAG_I]);
    wire  [15:0] addr_mask = 16'((17'h00001 << ADDR_LINES) - 17'h00001);

    // ========================================
    // arith_logic_unit: returns {overflow, carry, result}; holds no state
    function automatic logic [9:0] alu_fn(input ecpu_alu_e op, input logic [7:0] a,
                                          input logic [7:0] b, input logic cin);
        logic [8:0] s;
        logic       v;
        s = 9'h000;
        v = 1'b0;
        case (op)
            ALU_PASS: s = {1'b0, b};
            ALU_ADD:
            begin
                s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                v = (a[7] == b[7]) && (s[7] != a[7]);
            end
            ALU_SUB:
            begin
                s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
                v = (a[7] != b[7]) && (s[7] != a[7]);
            end
            ALU_AND: s = {1'b0, a & b};
            ALU_OR:  s = {1'b0, a | b};
            ALU_XOR: s = {1'b0, a ^ b};
            ALU_INC: s = {1'b0, a} + 9'h001;
            ALU_DEC: s = {1'b0, a} - 9'h001;
            default: s = 9'h000;
        endcase
        return {v, s};
    endfunction

    // negative and zero follow every value loaded or computed into acc, x or y
    function automatic logic [7:0] with_nz(input logic [7:0] p, input logic [7:0] val);
        p[FLAG_N] = val[7];
        p[FLAG_Z] = (val == 8'h00);
        return p;
    endfunction

    // ========================================
    // step sequencer and register transfers, one step per phase-one pulse
    always_comb
    begin
        alu_r           = 10'h000;
        next_pc         = pc;
        next_ir         = ir;
        next_acc        = acc;
        next_x_reg      = x_reg;
        next_y_reg      = y_reg;
        next_sp         = sp;
        next_status     = status;
        next_base_lo    = base_lo;
        next_base_hi    = base_hi;
        next_carry_tmp  = carry_tmp;
        next_int_active = int_active;
        next_int_nmi    = int_nmi;
        int_taken       = 1'b0;
        done            = 1'b0;
        addr_mux        = pc;
        dout_mux        = acc;
        wr_mux          = 1'b0;
        fetch_mux       = 1'b0;
        if (step == 3'h0)
        begin
            // interrupt replaces the fetch; pc is kept for the return
            if (int_req)
            begin
                int_taken       = 1'b1;
                next_int_active = 1'b1;
                next_int_nmi    = nmi_pend;
            end
            else
            begin
                fetch_mux       = 1'b1;
                next_ir         = data_in_in;
                next_pc         = pc_plus;
                next_int_active = 1'b0;
            end
        end
        else if (int_active)
        begin
            addr_mux = stack_adr;
            case (step)
                3'h1, 3'h2, 3'h3:
                begin
                    wr_mux   = 1'b1;
                    dout_mux = (step == 3'h1) ? pc[15:8] : (step == 3'h2) ? pc[7:0] : status;
                    if (step == 3'h3)
                    begin
                        dout_mux[FLAG_B]   = 1'b0;
                        next_status[FLAG_I] = 1'b1;
                    end
                    alu_r   = alu_fn(ALU_DEC, sp, 8'h00, 1'b0);
                    next_sp = alu_r[7:0];
                end
                3'h4:
                begin
                    addr_mux      = vec_adr;
                    next_pc[7:0]  = data_in_in;
                end
                default:
                begin
                    addr_mux      = {vec_adr[15:1], 1'b1};
                    next_pc[15:8] = data_in_in;
                    done          = 1'b1;
                end
            endcase
        end
        else
        begin
            case (op_cls)
                CLS_ALU, CLS_STORE:
                begin
                    // operand bytes come from the pc; zero-page modes pin the high byte
                    if (step == 3'h1 && op_mode != MODE_IMM)
                    begin
                        next_base_lo = data_in_in;
                        next_base_hi = ZERO_PAGE;
                        next_pc      = pc_plus;
                    end
                    else if (step == 3'h2 && op_mode == MODE_ZP_X)
                    begin
                        alu_r        = alu_fn(ALU_ADD, base_lo, x_reg, 1'b0);
                        next_base_lo = alu_r[7:0];               // carry dropped
                    end
                    else if (step == 3'h2 && op_mode == MODE_ABS_Y)
                    begin
                        next_base_hi = data_in_in;
                        next_pc      = pc_plus;
                    end
                    else if (step == 3'h3 && op_mode == MODE_ABS_Y)
                    begin
                        alu_r          = alu_fn(ALU_ADD, base_lo, y_reg, 1'b0);
                        next_base_lo   = alu_r[7:0];
                        next_carry_tmp = alu_r[8];
                    end
                    else if (step == 3'h4 && op_mode == MODE_ABS_Y)
                    begin
                        alu_r        = alu_fn(ALU_ADD, base_hi, 8'h00, carry_tmp);
                        next_base_hi = alu_r[7:0];
                    end
                    if (step == exec_step)
                    begin
                        done     = 1'b1;
                        addr_mux = (op_mode == MODE_IMM) ? pc : eff_adr;
                        if (op_mode == MODE_IMM)
                            next_pc = pc_plus;
                        if (op_cls == CLS_STORE)
                            wr_mux = 1'b1;
                        else
                        begin
                            case (op_sel)
                                3'h1: alu_r = alu_fn(ALU_ADD, acc, data_in_in, status[FLAG_C]);
                                3'h2: alu_r = alu_fn(ALU_SUB, acc, data_in_in, status[FLAG_C]);
                                3'h3: alu_r = alu_fn(ALU_AND, acc, data_in_in, 1'b0);
                                3'h4: alu_r = alu_fn(ALU_OR, acc, data_in_in, 1'b0);
                                3'h5: alu_r = alu_fn(ALU_XOR, acc, data_in_in, 1'b0);
                                3'h6: alu_r = alu_fn(ALU_SUB, acc, data_in_in, 1'b1);
                                default: alu_r = alu_fn(ALU_PASS, acc, data_in_in, 1'b0);
                            endcase
                            next_status = with_nz(status, alu_r[7:0]);
                            if (op_sel == 3'h1 || op_sel == 3'h2 || op_sel == 3'h6)
                                next_status[FLAG_C] = alu_r[8];
                            if (op_sel == 3'h1 || op_sel == 3'h2)
                                next_status[FLAG_V] = alu_r[9];
                            if (op_sel == 3'h7)
                                next_x_reg = alu_r[7:0];
                            else if (op_sel != 3'h6)
                                next_acc = alu_r[7:0];
                        end
                    end
                end
                CLS_IMPLIED:
                begin
                    done = 1'b1;
                    case (op_imp)
                        4'h0, 4'h1, 4'h2, 4'h3:
                        begin
                            alu_r = alu_fn(op_imp[0] ? ALU_DEC : ALU_INC,
                                           op_imp[1] ? y_reg : x_reg, 8'h00, 1'b0);
                            next_status = with_nz(status, alu_r[7:0]);
                            if (op_imp[1])
                                next_y_reg = alu_r[7:0];
                            else
                                next_x_reg = alu_r[7:0];
                        end
                        4'h4: begin next_x_reg = acc; next_status = with_nz(status, acc); end
                        4'h5: begin next_acc = x_reg; next_status = with_nz(status, x_reg); end
                        4'h6: begin next_y_reg = acc; next_status = with_nz(status, acc); end
                        4'h7: begin next_acc = y_reg; next_status = with_nz(status, y_reg); end
                        4'h8: next_sp = x_reg;
                        4'h9: begin next_x_reg = sp; next_status = with_nz(status, sp); end
                        4'ha, 4'hc:
                        begin
                            addr_mux = stack_adr;
                            wr_mux   = 1'b1;
                            dout_mux = op_imp[2] ? (status | 8'h10) : acc;
                            alu_r    = alu_fn(ALU_DEC, sp, 8'h00, 1'b0);
                            next_sp  = alu_r[7:0];
                        end
                        4'hb, 4'hd:
                        begin
                            // pull: bump the pointer first, read on the next step
                            addr_mux = stack_adr;
                            done     = (step == 3'h2);
                            if (step == 3'h1)
                            begin
                                alu_r   = alu_fn(ALU_INC, sp, 8'h00, 1'b0);
                                next_sp = alu_r[7:0];
                            end
                            else if (op_imp[1])
                                next_status = data_in_in;
                            else
                            begin
                                next_acc    = data_in_in;
                                next_status = with_nz(status, data_in_in);
                            end
                        end
                        4'he: next_status[FLAG_C] = ir[4];
                        default:
                        begin
                            // decimal mode is only ever touched by program
                            if (ir[5])
                                next_status[FLAG_D] = ir[4];
                            else
                                next_status[FLAG_I] = ir[4];
                        end
                    endcase
                end
                default:
                begin
                    case (ir[1:0])
                        2'h0:
                        begin
                            done = (step == 3'h2);
                            if (step == 3'h1)
                            begin
                                next_base_lo = data_in_in;
                                next_pc      = pc_plus;
                            end
                            else
                                next_pc = {data_in_in, base_lo};
                        end
                        2'h1:
                        begin
                            addr_mux = stack_adr;
                            done     = (step == 3'h4);
                            if (step != 3'h4)
                            begin
                                alu_r   = alu_fn(ALU_INC, sp, 8'h00, 1'b0);
                                next_sp = alu_r[7:0];
                            end
                            if (step == 3'h2)
                                next_status = data_in_in;
                            else if (step == 3'h3)
                                next_pc[7:0] = data_in_in;
                            else if (step == 3'h4)
                                next_pc[15:8] = data_in_in;
                        end
                        2'h2:
                        begin
                            done                = 1'b1;
                            next_status[FLAG_V] = 1'b0;
                        end
                        default: done = 1'b1;
                    endcase
                end
            endcase
        end
        next_step = done ? 3'h0 : step + 3'h1;
    end

    // ========================================
    // phase-one divider, free running so step spacing never varies
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in || step_en)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    // interrupt inputs sampled once per step so sync and address never move inside a step;
    // nmi must stay high for a whole step; a new edge in the taking step wins over the clear
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            nmi_prev <= 1'b0;
            nmi_pend <= 1'b0;
            irq_hold <= 1'b0;
        end
        else if (step_en)
        begin
            nmi_prev <= nmi_in;
            irq_hold <= irq_in;
            if (nmi_edge)
                nmi_pend <= 1'b1;
            else if (int_taken && nmi_pend)
                nmi_pend <= 1'b0;
        end
    end

    // register file update on phase one
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            step <= 3'h0;  pc <= PC_RESET;  ir <= 8'h00;  acc <= 8'h00;
            x_reg <= 8'h00;  y_reg <= 8'h00;  sp <= SP_RESET;  status <= STATUS_RESET;
            base_lo <= 8'h00;  base_hi <= 8'h00;  carry_tmp <= 1'b0;
            int_active <= 1'b0;  int_nmi <= 1'b0;
        end
        else if (step_en)
        begin
            step <= next_step;  pc <= next_pc;  ir <= next_ir;  acc <= next_acc;
            x_reg <= next_x_reg;  y_reg <= next_y_reg;  sp <= next_sp;
            status <= next_status | (8'h01 << FLAG_ONE);
            base_lo <= next_base_lo;  base_hi <= next_base_hi;  carry_tmp <= next_carry_tmp;
            int_active <= next_int_active;  int_nmi <= next_int_nmi;
        end
    end

    // ========================================
    // bus outputs; narrow parts simply leave upper lines low
    assign addr_out      = addr_mux & addr_mask;
    assign data_out      = dout_mux;
    assign write_out     = wr_mux;
    assign sync_out      = fetch_mux;
    assign phase_one_out = step_en;

endmodule
`default_nettype wire

// *** bench/ecpu_core_properties.sv ***
// port-level checks on the core's step timing, fetch and store addresses
// assumes the core is bound below with its default pin names
`timescale 1ns/100ps
`default_nettype none
module ecpu_core_props
    import ecpu_pkg::*;
#(
    parameter int ADDR_LINES = 16
)
(
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  data_in_in,
    input wire logic [15:0] addr_out,
    input wire logic        write_out,
    input wire logic        sync_out
    ,input wire logic       phase_one_out
);
    // ========================================
    // opcode fetch step; operands arrive two clocks later
    wire logic fetch;
    assign fetch = sync_out && phase_one_out;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    phase_fall_a: assert property (phase_one_out |=> !phase_one_out)
        else $error("phase pulse too long");
    phase_rise_a: assert property (!phase_one_out |=> phase_one_out)
        else $error("phase pulse missing");
    step_stand_a: assert property (!phase_one_out |=> $stable(addr_out)
        && $stable(sync_out) && $stable(write_out)) else $error("outputs moved inside a step");
    reset_fetch_a: assert property ($rose(reset_n_in) |-> !phase_one_out ##1
        (fetch && addr_out == PC_RESET)) else $error("no fetch from reset pc");
    imm_next_a: assert property (fetch && data_in_in[7:6] == 2'h0
        && data_in_in[1:0] == 2'h0 |=> ##1 addr_out == $past(addr_out, 2) + 16'h1 ##2 sync_out
        && addr_out == $past(addr_out, 4) + 16'h2) else $error("pc not stepped");
    zp_store_a: assert property (fetch && data_in_in[7:6] == 2'h1
        && data_in_in[1:0] == 2'h1 |=> ##3 write_out && addr_out == {8'h00, $past(data_in_in, 2)})
        else $error("zero page store address wrong");
    zpx_page_a: assert property (fetch && data_in_in[7:6] == 2'h1
        && data_in_in[1:0] == 2'h2 |=> ##5 write_out && addr_out[15:8] == ZERO_PAGE)
        else $error("indexed store left page zero");
    push_page_a: assert property (fetch && data_in_in == 8'h8a |=> ##1 write_out
        && addr_out[15:8] == STACK_PAGE) else $error("push outside page one");
    sync_read_a: assert property (sync_out |-> !write_out)
        else $error("write during fetch");
endmodule
bind ecpu_core ecpu_core_props #(.ADDR_LINES(ADDR_LINES)) u_props (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .data_in_in(data_in_in), .addr_out(addr_out),
    .write_out(write_out), .sync_out(sync_out), .phase_one_out(phase_one_out));
`default_nettype wire

// *** bench/ecpu_mem.sv ***
// program and data memory facing the core; reads answer within the step
// assumes writes land on the phase-one edge, as the core's steps do
`timescale 1ns/100ps
`default_nettype none
module ecpu_mem
(
    input  wire logic        clk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        write_in,
    input  wire logic        phase_in,
    output logic      [7:0]  rdata_out
);
    logic [7:0] mem [0:65535];
    // ========================================
    // program: stack pointer is loaded before any push or interrupt
    initial
    begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'hff; // unused bytes are no-ops
        mem[0] = 8'h38; mem[1] = 8'hff; mem[2] = 8'h88;
        mem[3] = 8'h00; mem[4] = 8'h05; mem[5] = 8'h41; mem[6] = 8'h10;
        mem[7] = 8'h84; mem[8] = 8'h42; mem[9] = 8'hfe; mem[10] = 8'h8a;
        mem[11] = 8'h8a; mem[12] = 8'hc0; mem[13] = 8'h0c; mem[14] = 8'h00;
        mem[16'hfffa] = 8'h20; mem[16'hfffb] = 8'h00;
        // nmi handler: add with carry out, A to Y, Y+1, absolute indexed store, return
        mem[16'h0020] = 8'h08; mem[16'h0021] = 8'hfd; mem[16'h0022] = 8'h86;
        mem[16'h0023] = 8'h82; mem[16'h0024] = 8'h43; mem[16'h0025] = 8'hfe;
        mem[16'h0026] = 8'h04; mem[16'h0027] = 8'hc1;
    end
    assign rdata_out = mem[addr_in];
    // store on the step edge only
    always @(posedge clk_in)
        if (phase_in && write_in) mem[addr_in] <= wdata_in;
endmodule
`default_nettype wire

// *** bench/test_eight_bit_cpu_core_datapath.sv ***
// bench for the core running a small program against the memory model
// assumes the memory model holds the program and vectors at time zero
`timescale 1ns/100ps
`default_nettype none
module test_eight_bit_cpu_core_datapath;
    import ecpu_pkg::*;
    logic clk_in = 0, reset_n_in = 0, irq_in = 0, nmi_in = 0;
    wire logic [15:0] addr;
    wire logic [7:0] rdata, wdata;
    wire logic wr, sync, ph;
    int n_fail = 0, compares = 0, cyc = 0;
    initial forever #2 clk_in = ~clk_in;
    ecpu_core #(.ADDR_LINES(16)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .data_in_in(rdata), .irq_in(irq_in), .nmi_in(nmi_in), .addr_out(addr),
        .data_out(wdata), .write_out(wr), .sync_out(sync), .phase_one_out(ph));
    ecpu_mem u_mem (.clk_in(clk_in), .addr_in(addr), .wdata_in(wdata), .write_in(wr),
        .phase_in(ph), .rdata_out(rdata));
    // ========================================
    // hang guard; the whole run needs well under a thousand clocks
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 4000) begin n_fail++; close_out(); end
    end
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end
    endtask
    // bounded wait for an opcode fetch at a given address
    task wait_fetch(input logic [15:0] a);
        int i;
        for (i = 0; i < 400 && !(sync === 1'b1 && addr === a); i++) @(negedge clk_in);
        compares++;
        if (i == 400) begin n_fail++; $display("[ERR] %0t no fetch at %h", $time, a); end
    endtask
    task run_program;
        wait_fetch(16'h000c);
        chk8(u_mem.mem[16'h0010], 8'h05);
        chk8(u_mem.mem[16'h0003], 8'h05);
        chk8(u_mem.mem[16'h0103], 8'hff);
        chk8(u_mem.mem[16'h01ff], 8'h05);
        chk8(u_mem.mem[16'h01fe], 8'h05);
    endtask
    task nmi_test;
        @(negedge clk_in) nmi_in = 1;
        wait_fetch(16'h0020);
        chk8(u_mem.mem[16'h01fd], 8'h00);
        chk8(u_mem.mem[16'h01fc], 8'h0c);
        chk8(u_mem.mem[16'h01fb], 8'h24);
        nmi_in = 0;
        wait_fetch(16'h000c);
        chk8(u_mem.mem[16'h0501], 8'h02);
    endtask
    // reset leaves the interrupt mask set, so the request must be ignored
    task irq_test;
        logic [7:0] hits;
        hits = 8'h00;
        irq_in = 1;
        repeat (40)
        begin
            @(negedge clk_in);
            if (wr !== 1'b0 || addr === IRQ_VECTOR) hits++;
        end
        chk8(hits, 8'h00);
        chk8(u_mem.mem[16'h01fa], 8'hff);
        irq_in = 0;
    endtask
    task close_out;
        if (n_fail == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge clk_in);
        reset_n_in = 1;
        run_program();
        nmi_test();
        irq_test();
        close_out();
    end
endmodule
`default_nettype wire
